// ===== rtl/ctt_core.sv
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module ctt_core (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // clock sources from the system
  input  wire logic        highClkTick,
  input  wire logic        timebaseTick,
  // pins
  input  wire logic        extClockPin,
  output logic             timerOutputPin,
  // interrupt
  output logic             irq
);

  typedef struct packed {
    logic [7:0]  ctrlPri;
    logic [7:0]  ctrlSec;
    logic [9:0]  fine;
    logic [9:0]  cnt;
    logic        wrapPend;
    logic        runPrev;
    logic        extPrev;
    logic [5:0]  pre;
    logic [5:0]  hiPre;
    logic        pinLvl;
    logic [1:0]  intSts;
    logic [1:0]  intMask;
    logic [31:0] rdata;
    logic        ready;
    logic        slvErr;
    logic        outPin;
    logic        irqOut;
  } ctt_state_t;

  ctt_state_t s_q;
  ctt_state_t s_d;

  // decoded controls
  logic              hold;
  logic              run;
  logic              runRise;
  ctt_pkg::ctt_clksrc_t clkSel;
  logic [2:0]        coarse;
  ctt_pkg::ctt_mode_t mode;
  logic [1:0]        action;
  logic              initLvl;
  logic              invert;
  logic              swap;
  logic              clrSrc;
  // counting
  logic              tick;
  logic              adv;
  logic [9:0]        nxt;
  logic [9:0]        coarseVal;
  logic              coarseHit;
  logic              fineHit;
  logic              selMatch;
  logic [9:0]        duty;
  logic              pwmActive;
  // bus
  logic              wrEn;
  logic              setupRd;
  logic [1:0]        intSet;
  logic [1:0]        intClr;

  assign hold    = s_q.ctrlPri[ctt_pkg::HOLD_BIT];
  assign run     = s_q.ctrlPri[ctt_pkg::RUN_BIT];
  assign clkSel  = ctt_pkg::ctt_clksrc_t'(s_q.ctrlPri[ctt_pkg::CLKSEL_LSB +: 3]);
  assign coarse  = s_q.ctrlPri[ctt_pkg::COARSE_LSB +: 3];
  assign mode    = ctt_pkg::ctt_mode_t'(s_q.ctrlSec[ctt_pkg::MODE_LSB +: 2]);
  assign action  = s_q.ctrlSec[ctt_pkg::ACTION_LSB +: 2];
  assign initLvl = s_q.ctrlSec[ctt_pkg::INIT_BIT];
  assign invert  = s_q.ctrlSec[ctt_pkg::INVERT_BIT];
  assign swap    = s_q.ctrlSec[ctt_pkg::SWAP_BIT];
  assign clrSrc  = s_q.ctrlSec[ctt_pkg::CLRSRC_BIT];
  // rising edge of the run bit, seen the cycle after the write
  assign runRise = run && !s_q.runPrev;

  // counting clock selection; divided clocks come from free prescalers
  always_comb
  begin
    case (clkSel)
      ctt_pkg::CTT_SRC_SYS4: tick = (s_q.pre[1:0] == ctt_pkg::DIV4_MASK[1:0]);
      ctt_pkg::CTT_SRC_SYS:  tick = 1'b1;
      ctt_pkg::CTT_SRC_HI16: tick = highClkTick && (s_q.hiPre[3:0] == ctt_pkg::DIV16_MASK[3:0]);
      ctt_pkg::CTT_SRC_HI64: tick = highClkTick && (s_q.hiPre == ctt_pkg::DIV64_MASK);
      ctt_pkg::CTT_SRC_TBC0: tick = timebaseTick;
      ctt_pkg::CTT_SRC_TBC1: tick = timebaseTick;
      ctt_pkg::CTT_SRC_EXTR: tick = extClockPin && !s_q.extPrev;
      default:               tick = !extClockPin && s_q.extPrev;
    endcase
  end

  // comparators look at the value the counter is about to take
  assign adv       = run && !hold && tick && !runRise;
  assign nxt       = s_q.cnt + 10'h001;
  assign coarseVal = {coarse, 7'h00};
  assign coarseHit = (coarse == 3'h0) ? (s_q.cnt == ctt_pkg::COUNT_MAX)
                                      : (nxt == coarseVal);
  assign fineHit   = (nxt == s_q.fine);
  // overflow needs no pending clear: the wrap itself lands on zero
  always_comb
  begin
    if (mode == ctt_pkg::CTT_MODE_PWM)
      selMatch = swap ? fineHit : (coarseHit && coarse != 3'h0);
    else if (clrSrc)
      selMatch = fineHit;
    else
      selMatch = coarseHit && coarse != 3'h0;
  end

  // pwm duty from whichever comparator is not the period
  assign duty      = swap ? coarseVal : s_q.fine;
  assign pwmActive = (s_q.cnt < duty);

  // apb: setup cycle prepares answer, access cycle completes it
  assign setupRd = psel && !penable && !pwrite;
  assign wrEn    = psel && penable && pwrite && s_q.ready;
  assign intClr  = (wrEn && paddr == ctt_pkg::ADDR_INT_STAT) ? pwdata[1:0] : 2'h0;

  // next state
  always_comb
  begin
    s_d        = s_q;
    intSet     = 2'h0;
    s_d.pre    = s_q.pre + 6'h01;
    s_d.hiPre  = highClkTick ? s_q.hiPre + 6'h01 : s_q.hiPre;
    s_d.extPrev = extClockPin;
    s_d.runPrev = run;

    // counter; software reaches it only through the run edge
    if (runRise)
    begin
      s_d.cnt      = 10'h000;
      s_d.wrapPend = 1'b0;
      s_d.pinLvl   = initLvl;
    end
    else if (adv)
    begin
      if (s_q.wrapPend)
      begin
        s_d.cnt      = 10'h000;
        s_d.wrapPend = 1'b0;
      end
      else
      begin
        s_d.cnt      = nxt;
        s_d.wrapPend = selMatch;
        intSet[ctt_pkg::INT_FINE_BIT]   = fineHit;
        // coarse flag suppressed when fine clears outside pwm
        intSet[ctt_pkg::INT_COARSE_BIT] = coarseHit &&
          (mode == ctt_pkg::CTT_MODE_PWM || !clrSrc);
        if (mode == ctt_pkg::CTT_MODE_CMP && fineHit)
        begin
          case (action)
            2'h1:    s_d.pinLvl = 1'b0;
            2'h2:    s_d.pinLvl = 1'b1;
            2'h3:    s_d.pinLvl = !s_q.pinLvl;
            default: s_d.pinLvl = s_q.pinLvl;
          endcase
        end
      end
    end

    // pin per mode; timer mode leaves the pin idle
    case (mode)
      ctt_pkg::CTT_MODE_PWM:
        case (action)
          2'h1:    s_d.outPin = initLvl ^ invert;
          2'h2:    s_d.outPin = (pwmActive ? initLvl : !initLvl) ^ invert;
          default: s_d.outPin = !initLvl ^ invert;
        endcase
      ctt_pkg::CTT_MODE_TMR: s_d.outPin = 1'b0;
      default:               s_d.outPin = s_d.pinLvl ^ invert;
    endcase

    // register writes at the completing access edge
    if (wrEn)
    begin
      if (paddr == ctt_pkg::ADDR_CTRL_PRI)
        s_d.ctrlPri = pwdata[7:0];
      else if (paddr == ctt_pkg::ADDR_CTRL_SEC)
        s_d.ctrlSec = pwdata[7:0];
      else if (paddr == ctt_pkg::ADDR_FINE_LO)
        s_d.fine[7:0] = pwdata[7:0];
      else if (paddr == ctt_pkg::ADDR_FINE_HI)
        s_d.fine[9:8] = pwdata[1:0];
      else if (paddr == ctt_pkg::ADDR_INT_MASK)
        s_d.intMask = pwdata[1:0];
    end

    // sticky flags: a new event wins over the clear
    s_d.intSts = (s_q.intSts & ~intClr) | intSet;
    s_d.irqOut = |(s_d.intSts & s_d.intMask);

    // answer prepared in setup, presented in the access phase
    s_d.ready  = psel && !penable;
    s_d.slvErr = 1'b0;
    s_d.rdata  = 32'h0000_0000;
    if (psel && !penable)
    begin
      if (paddr == ctt_pkg::ADDR_CTRL_PRI)
        s_d.rdata[7:0] = s_q.ctrlPri;
      else if (paddr == ctt_pkg::ADDR_CTRL_SEC)
        s_d.rdata[7:0] = s_q.ctrlSec;
      else if (paddr == ctt_pkg::ADDR_CNT_LO)
        s_d.rdata[7:0] = s_q.cnt[7:0];
      else if (paddr == ctt_pkg::ADDR_CNT_HI)
        s_d.rdata[1:0] = s_q.cnt[9:8];
      else if (paddr == ctt_pkg::ADDR_FINE_LO)
        s_d.rdata[7:0] = s_q.fine[7:0];
      else if (paddr == ctt_pkg::ADDR_FINE_HI)
        s_d.rdata[1:0] = s_q.fine[9:8];
      else if (paddr == ctt_pkg::ADDR_INT_STAT)
        s_d.rdata[1:0] = s_q.intSts;
      else if (paddr == ctt_pkg::ADDR_INT_MASK)
        s_d.rdata[1:0] = s_q.intMask;
      else
        s_d.slvErr = 1'b1; // unmapped
    end
    if (!setupRd)
      s_d.rdata = (psel && !penable) ? 32'h0000_0000 : s_q.rdata;
  end

  // state register; enable low freezes everything
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q         <= '0;
      s_q.ctrlPri <= ctt_pkg::CTRL_PRI_RESET;
      s_q.ctrlSec <= ctt_pkg::CTRL_SEC_RESET;
      s_q.fine    <= ctt_pkg::FINE_RESET;
      s_q.intMask <= ctt_pkg::INT_MASK_RESET;
    end
    else if (clkEn)
      s_q <= s_d;
  end

  assign prdata         = s_q.rdata;
  assign pready         = s_q.ready;
  assign pslverr        = s_q.slvErr;
  assign timerOutputPin = s_q.outPin;
  assign irq            = s_q.irqOut;

  // checks
  sequence clearArm;
    clkEn && adv && !s_q.wrapPend && selMatch;
  endsequence

  sequence nextTick;
    clkEn && adv;
  endsequence

  a_count_up: assert property (@(posedge clk) disable iff (rst)
    clkEn && adv && !s_q.wrapPend |=> s_q.cnt == $past(nxt))
    else $error("counter did not step up by one");

  a_coarse_top: assert property (@(posedge clk) disable iff (rst)
    clkEn && adv && !s_q.wrapPend && coarse != 3'h0 && nxt == coarseVal
      && (mode == ctt_pkg::CTT_MODE_PWM || !clrSrc)
    |=> s_q.intSts[ctt_pkg::INT_COARSE_BIT] && s_q.cnt[9:7] == $past(coarse))
    else $error("coarse match not flagged on top bits");

  a_no_sw_write: assert property (@(posedge clk) disable iff (rst)
    !(clkEn && (adv || runRise)) |=> $stable(s_q.cnt))
    else $error("counter changed without tick or run edge");

  a_match_clears: assert property (@(posedge clk) disable iff (rst)
    clearArm |=> s_q.wrapPend)
    else $error("clearing match not armed");

  a_restart_zero: assert property (@(posedge clk) disable iff (rst)
    s_q.wrapPend ##0 nextTick |=> s_q.cnt == 10'h000 && !s_q.wrapPend)
    else $error("counter did not restart from zero");

  a_hold_keeps: assert property (@(posedge clk) disable iff (rst)
    hold && !runRise ##1 hold && !runRise |-> $stable(s_q.cnt))
    else $error("counter moved while held");

  a_run_rise: assert property (@(posedge clk) disable iff (rst)
    clkEn && runRise |=> s_q.cnt == 10'h000 ##1 !runRise)
    else $error("run rising edge did not clear counter");

  a_pin_initial: assert property (@(posedge clk) disable iff (rst)
    clkEn && runRise && mode == ctt_pkg::CTT_MODE_CMP
    |=> timerOutputPin == ($past(initLvl) ^ $past(invert)))
    else $error("pin not returned to initial level");

  a_timer_idle: assert property (@(posedge clk) disable iff (rst)
    clkEn && mode == ctt_pkg::CTT_MODE_TMR |=> !timerOutputPin)
    else $error("pin driven in timer mode");

  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    clkEn |=> irq == |(s_q.intSts & s_q.intMask))
    else $error("interrupt level disagrees with flags");

endmodule // ctt_core

// ===== rtl/ctt_pkg.sv
package ctt_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] ADDR_CTRL_PRI   = 8'h00;
  localparam logic [7:0] ADDR_CTRL_SEC   = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO     = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI     = 8'h0c;
  localparam logic [7:0] ADDR_FINE_LO    = 8'h10;
  localparam logic [7:0] ADDR_FINE_HI    = 8'h14;
  localparam logic [7:0] ADDR_INT_STAT   = 8'h18;
  localparam logic [7:0] ADDR_INT_MASK   = 8'h1c;

  // primary control fields
  localparam int HOLD_BIT      = 7;
  localparam int CLKSEL_LSB    = 4;
  localparam int RUN_BIT       = 3;
  localparam int COARSE_LSB    = 0;

  // secondary control fields
  localparam int MODE_LSB      = 6;
  localparam int ACTION_LSB    = 4;
  localparam int INIT_BIT      = 3;
  localparam int INVERT_BIT    = 2;
  localparam int SWAP_BIT      = 1;
  localparam int CLRSRC_BIT    = 0;

  // interrupt status / mask bits
  localparam int INT_FINE_BIT   = 0;
  localparam int INT_COARSE_BIT = 1;

  // values after reset
  localparam logic [7:0] CTRL_PRI_RESET = 8'h00;
  localparam logic [7:0] CTRL_SEC_RESET = 8'h00;
  localparam logic [9:0] FINE_RESET     = 10'h000;
  localparam logic [1:0] INT_MASK_RESET = 2'h0;

  // prescaler terminal values for the divided internal clocks; counter top value and coarse field shift
  localparam logic [5:0] DIV4_MASK      = 6'h03;
  localparam logic [5:0] DIV16_MASK     = 6'h0f;
  localparam logic [5:0] DIV64_MASK     = 6'h3f;
  localparam logic [9:0] COUNT_MAX      = 10'h3ff;
  localparam int         COARSE_SHIFT   = 7;

  typedef enum logic [2:0] {
    CTT_SRC_SYS4, CTT_SRC_SYS, CTT_SRC_HI16, CTT_SRC_HI64,
    CTT_SRC_TBC0, CTT_SRC_TBC1, CTT_SRC_EXTR, CTT_SRC_EXTF
  } ctt_clksrc_t;

  typedef enum logic [1:0] {
    CTT_MODE_CMP, CTT_MODE_UNDEF, CTT_MODE_PWM, CTT_MODE_TMR
  } ctt_mode_t;

endpackage

// ===== tb/ctt_pin_model.sv
`timescale 1ns/1ns
// far side: external clock pin and the internal tick sources
module ctt_pin_model (
  // clock
  input  wire logic clk,
  // pin and ticks
  output logic      extPin,
  output logic      hiTick,
  output logic      tbTick
);
  logic [2:0] divQ = 3'h0;

  // free running divider; ticks are one-cycle pulses
  always @(posedge clk)
  begin
    divQ <= divQ + 3'h1;
  end
  assign hiTick = divQ[0];
  assign tbTick = &divQ;

  // pin idles low; high held two cycles and low three between pulses, so the sampler sees it
  initial extPin = 1'b0;
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk);
      extPin <= 1'b1;
      repeat (2) @(posedge clk);
      extPin <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule // ctt_pin_model

// ===== tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic        clk, rst, clkEn, psel, penable, pwrite, pready, pslverr;
  logic        hiTick, tbTick, extPin, pinOut, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, lastRd, f;
  logic [33:0] expQ[$];
  int          errCount = 0;
  int          compares = 0;

  ctt_core ctt_core_inst (.clk(clk), .rst(rst), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .highClkTick(hiTick),
    .timebaseTick(tbTick), .extClockPin(extPin), .timerOutputPin(pinOut), .irq(irq));
  ctt_pin_model ctt_pin_model_inst (.clk(clk), .extPin(extPin), .hiTick(hiTick),
    .tbTick(tbTick));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    compares++;
    if (seen !== want)
    begin
      errCount++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic stopTest();
    $display("compares %0d mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one apb transfer; held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // read notes {dont care, slave error, data} before the transfer
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic dc = 1'b0);
    expQ.push_back({dc, e});
    apb(1'b0, a, 32'h0);
    @(negedge clk);
  endtask

  task automatic burst(input int n);
    ctt_pin_model_inst.pulse(n);
    repeat (6) @(posedge clk);
  endtask

  // watcher: oldest note compared to each completed read, unless the note is marked dont care
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0)
    begin
      lastRd = prdata;
      if (!expQ[0][33])
        check({1'b0, pslverr, prdata}, {1'b0, expQ[0][32:0]});
      void'(expQ.pop_front());
    end
  end

  initial
  begin
    #200000;
    errCount++;
    $display("BAD t=%0t watchdog expired", $time);
    stopTest();
  end

  initial
  begin
    f = $urandom(53038);
    {rst, clkEn, psel, penable, pwrite, paddr, pwdata} = {2'h3, 43'h0};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // reset values, then an unmapped word
    for (int i = 0; i < 9; i++)
      rd(8'(i * 4), {i == 8, 32'h0});
    $display("reset test done");
    // fine value round trip; count write has no effect
    f = $urandom & 32'h3ff;
    apb(1'b1, ctt_pkg::ADDR_FINE_LO, f & 32'hff);
    apb(1'b1, ctt_pkg::ADDR_FINE_HI, f >> 8);
    apb(1'b1, ctt_pkg::ADDR_CNT_LO, 32'hff);
    rd(ctt_pkg::ADDR_FINE_LO, {1'b0, f & 32'hff});
    rd(ctt_pkg::ADDR_FINE_HI, {1'b0, f >> 8});
    rd(ctt_pkg::ADDR_CNT_LO, 33'h0);
    // rising pin edges, hold, run off, falling edges
    apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'h68);
    burst(5);
    rd(ctt_pkg::ADDR_CNT_LO, 33'h5);
    apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'he8);
    burst(3);
    rd(ctt_pkg::ADDR_CNT_LO, 33'h5);
    apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'h68);
    burst(2);
    rd(ctt_pkg::ADDR_CNT_LO, 33'h7);
    apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'h70);
    burst(4);
    rd(ctt_pkg::ADDR_CNT_LO, 33'h7);
    apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'h78);
    burst(3);
    rd(ctt_pkg::ADDR_CNT_LO, 33'h3);
    $display("count test done");
    // fine match clears; flag, mask and write-one-to-clear
    apb(1'b1, ctt_pkg::ADDR_FINE_LO, 32'h5);
    apb(1'b1, ctt_pkg::ADDR_FINE_HI, 32'h0);
    apb(1'b1, ctt_pkg::ADDR_CTRL_SEC, 32'h1);
    apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'h60);
    apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'h68);
    burst(7);
    rd(ctt_pkg::ADDR_CNT_LO, 33'h1);
    rd(ctt_pkg::ADDR_INT_STAT, 33'h1);
    check({33'h0, irq}, 34'h0);
    apb(1'b1, ctt_pkg::ADDR_INT_MASK, 32'h1);
    repeat (2) @(posedge clk);
    check({33'h0, irq}, 34'h1);
    apb(1'b1, ctt_pkg::ADDR_INT_STAT, 32'h1);
    repeat (2) @(posedge clk);
    check({33'h0, irq}, 34'h0);
    // coarse code 1 clears at 128; run rising sets initial pin level
    apb(1'b1, ctt_pkg::ADDR_CTRL_SEC, 32'h8);
    apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'h61);
    apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'h69);
    repeat (2) @(posedge clk);
    check({33'h0, pinOut}, 34'h1);
    burst(130);
    rd(ctt_pkg::ADDR_CNT_LO, 33'h1);
    rd(ctt_pkg::ADDR_CNT_HI, 33'h0);
    rd(ctt_pkg::ADDR_INT_STAT, 33'h3);
    $display("clear test done");
    // every internal source advances the count
    for (int c = 0; c < 6; c++)
    begin
      apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'(c << 4));
      apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'(c << 4) | 32'h8);
      repeat (300) @(posedge clk);
      rd(ctt_pkg::ADDR_CNT_LO, 33'h0, 1'b1);
      check({33'h0, lastRd != 32'h0}, 34'h1);
    end
    $display("source test done");
    // timer mode idles the pin; compare toggle; run edge restores pin
    apb(1'b1, ctt_pkg::ADDR_CTRL_SEC, 32'hc8);
    repeat (2) @(posedge clk);
    check({33'h0, pinOut}, 34'h0);
    apb(1'b1, ctt_pkg::ADDR_FINE_LO, 32'h3);
    apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'h61);
    apb(1'b1, ctt_pkg::ADDR_CTRL_SEC, 32'h38);
    apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'h69);
    burst(3);
    check({33'h0, pinOut}, 34'h0);
    apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'h61);
    apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'h69);
    repeat (2) @(posedge clk);
    check({33'h0, pinOut}, 34'h1);
    // pwm waveform, active high, duty of three ticks
    apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'h61);
    apb(1'b1, ctt_pkg::ADDR_CTRL_SEC, 32'ha8);
    apb(1'b1, ctt_pkg::ADDR_CTRL_PRI, 32'h69);
    repeat (3) @(posedge clk);
    check({33'h0, pinOut}, 34'h1);
    burst(3);
    check({33'h0, pinOut}, 34'h0);
    // enable low freezes the counter against pin edges
    @(posedge clk);
    clkEn <= 1'b0;
    burst(2);
    clkEn <= 1'b1;
    rd(ctt_pkg::ADDR_CNT_LO, 33'h3);
    $display("mode test done");
    stopTest();
  end
endmodule // testbench
